// ===== logic/swlm_pkg.sv
// Shared constants and types for the write lane mask block.
package swlm_pkg;
    // Data width of each variant.
    localparam int W_X8 = 8;
    localparam int W_X9 = 9;
    localparam int W_X18 = 18;
    localparam int W_X36 = 36;
    // Lane width for byte-lane variants and nibble width for the x8 variant.
    localparam int LANE_W = 9;
    localparam int NIB_W = 4;
    // Words per write burst.
    localparam int BURST_LEN = 4;
    localparam int BEAT_IDX_W = 2;
    // Default array depth (locations) for the model array.
    localparam int DEPTH_DEF = 16;
    // Reset value of the beat counter.
    localparam logic [1:0] BEAT_RST = 2'h0;
    typedef enum logic [1:0] {
        SWLM_IDLE = 2'b00,
        SWLM_BURST = 2'b01
    } swlm_state_t;
endpackage

// ===== logic/swlm_lane_if.sv
// Interface carrying one masked write beat from the capture logic to the lane merger.
`timescale 1ns/1ps
`default_nettype none
interface swlm_lane_if #(
    parameter int WIDTH = 36,
    parameter int LANES = 4
);
    logic [WIDTH-1:0] old_word;
    logic [WIDTH-1:0] new_word;
    logic [LANES-1:0] sel_n;
    logic [WIDTH-1:0] merged;
    modport cap (output old_word, output new_word, output sel_n, input merged);
    modport mrg (input old_word, input new_word, input sel_n, output merged);
endinterface
`default_nettype wire

// ===== logic/swlm_lane_merge.sv
// Lane merger: picks each lane from the new word or the stored word by its select.
`timescale 1ns/1ps
`default_nettype none
module swlm_lane_merge #(
    parameter int WIDTH = 36,
    parameter int LANES = 4
) (
    // Beat to merge
    swlm_lane_if.mrg lane
);
    localparam int LW = WIDTH / LANES;
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            // A low select takes the new lane, a high one keeps the old.
            assign lane.merged[g*LW +: LW] = lane.sel_n[g] ? lane.old_word[g*LW +: LW]
                                                           : lane.new_word[g*LW +: LW];
        end
    endgenerate
endmodule
`default_nettype wire

// ===== logic/swlm_write_lane_mask.sv
// Write data port lane masking for a four-word burst DDR synchronous SRAM.
// Overview of operation
// - x8: low nibble select low, high select high stores bits 3:0 only.
// - x8: high nibble select low, low select high stores bits 7:4 only.
// - x18: select 0 gates bits 8:0, select 1 bits 17:9; high keeps.
// - x36: all four selects low store the whole 36-bit word.
// - x36: selects 0..3 gate lanes 8:0, 17:9, 26:18, 35:27 when low.
// - x9: single select low stores bits 8:0; high stores nothing.
// - All selects high leave the addressed word untouched for that beat.
// - Selects are sampled per beat, each applying only to its own beat.
// - Each clock carries two beats, one per input clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module swlm_write_lane_mask #(
    parameter int WIDTH = 36,
    parameter int LANES = 4,
    parameter int DEPTH = swlm_pkg::DEPTH_DEF,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Write burst start, burst base address
    input wire logic wr_start,
    input wire logic [AW-1:0] wr_addr,
    // Beat on the positive input clock edge
    input wire logic [WIDTH-1:0] pos_data,
    input wire logic [LANES-1:0] pos_sel_n,
    // Beat on the negative input clock edge
    input wire logic [WIDTH-1:0] neg_data,
    input wire logic [LANES-1:0] neg_sel_n,
    // Array readback port and burst busy flag
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    output logic busy
);
    // The two edges of the input clocks are presented as two beats per core_clk
    // cycle, so the whole block runs on one clock with both beats in parallel.
    typedef struct packed {
        swlm_pkg::swlm_state_t st;
        logic [swlm_pkg::BEAT_IDX_W-1:0] beat;
        logic [AW-1:0] base;
        logic [WIDTH-1:0] rd;
        logic busy;
    } swlm_st_t;

    swlm_st_t s_q, s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] addr_p, addr_n;
    logic [swlm_pkg::BEAT_IDX_W-1:0] beat_now, beat_nx;
    logic in_burst;

    swlm_lane_if #(.WIDTH(WIDTH), .LANES(LANES)) lane_p ();
    swlm_lane_if #(.WIDTH(WIDTH), .LANES(LANES)) lane_n ();

    swlm_lane_merge #(.WIDTH(WIDTH), .LANES(LANES)) u_merge_p (.lane(lane_p.mrg));
    swlm_lane_merge #(.WIDTH(WIDTH), .LANES(LANES)) u_merge_n (.lane(lane_n.mrg));

    // Burst starts with beats A and A+1 in the same cycle as wr_start.
    assign in_burst = wr_start || (s_q.st == swlm_pkg::SWLM_BURST);
    assign beat_now = wr_start ? swlm_pkg::BEAT_RST : s_q.beat;
    assign beat_nx = beat_now + 2'h1;
    // Each beat's position selects its own burst word address; the sum wraps at
    // the array size, so a burst may start on the last words.
    assign addr_p = (wr_start ? wr_addr : s_q.base) + AW'(beat_now);
    assign addr_n = (wr_start ? wr_addr : s_q.base) + AW'(beat_nx);

    // Each beat carries its own sampled mask to its own merger.
    assign lane_p.old_word = mem_q[addr_p];
    assign lane_p.new_word = pos_data;
    assign lane_p.sel_n = pos_sel_n;
    assign lane_n.old_word = mem_q[addr_n];
    assign lane_n.new_word = neg_data;
    assign lane_n.sel_n = neg_sel_n;

    always_comb
    begin
        s_d = s_q;
        s_d.rd = mem_q[rd_addr];
        case (s_q.st)
            swlm_pkg::SWLM_IDLE:
            begin
                if (wr_start)
                begin
                    s_d.st = swlm_pkg::SWLM_BURST;
                    s_d.base = wr_addr;
                    s_d.beat = 2'h2;
                end
            end
            swlm_pkg::SWLM_BURST:
            begin
                // A start here is against the rules; it is taken as a fresh burst so
                // that the second cycle's addresses follow the beats actually written.
                if (wr_start)
                begin
                    s_d.base = wr_addr;
                    s_d.beat = 2'h2;
                end
                else
                begin
                    s_d.st = swlm_pkg::SWLM_IDLE;
                    s_d.beat = swlm_pkg::BEAT_RST;
                end
            end
            default:
            begin
                s_d.st = swlm_pkg::SWLM_IDLE;
            end
        endcase
        s_d.busy = (s_d.st == swlm_pkg::SWLM_BURST);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Lanes with a high select write back the stored value, so an all-high mask
    // leaves the word as it was; the x9 variant is the one-lane case.
    always_ff @(posedge core_clk)
    begin
        if (in_burst)
        begin
            mem_q[addr_p] <= lane_p.merged;
            mem_q[addr_n] <= lane_n.merged;
        end
    end

    // Readback shows the word as it stood before this edge's writes, so a read of
    // a word under write returns the older value.
    assign rd_data = s_q.rd;
    assign busy = s_q.busy;

    // Helpers for checks: the words that each beat is about to overwrite.
    logic [WIDTH-1:0] chk_old;
    logic [WIDTH-1:0] chk_old_n;
    assign chk_old = mem_q[addr_p];
    assign chk_old_n = mem_q[addr_n];

    // The checks need the two beats of a cycle on different words; with a one-word
    // array they would alias and the negative beat would win.
    sequence beat_all_high;
        in_burst && (&pos_sel_n) && (addr_p != addr_n);
    endsequence

    sequence neg_all_high;
        in_burst && (&neg_sel_n) && (addr_p != addr_n);
    endsequence

    sequence burst_open;
        wr_start && !busy;
    endsequence

    sequence burst_tail;
        busy ##1 !busy;
    endsequence

    keep_masked_word_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        beat_all_high |=> (mem_q[$past(addr_p)] == $past(chk_old)))
        else $error("word changed with all selects high");

    keep_neg_word_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        neg_all_high |=> (mem_q[$past(addr_n)] == $past(chk_old_n)))
        else $error("word changed with all negative beat selects high");

    full_word_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_burst && pos_sel_n == '0 && addr_p != addr_n)
        |=> (mem_q[$past(addr_p)] == $past(pos_data)))
        else $error("full write not stored");

    neg_full_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_burst && neg_sel_n == '0 && addr_p != addr_n)
        |=> (mem_q[$past(addr_n)] == $past(neg_data)))
        else $error("negative beat full write not stored");

    lane0_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_burst && !neg_sel_n[0] && addr_p != addr_n)
        |=> (mem_q[$past(addr_n)][WIDTH/LANES-1:0] == $past(neg_data[WIDTH/LANES-1:0])))
        else $error("negative beat lane 0 not stored");

    lane0_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_burst && pos_sel_n[0] && addr_p != addr_n)
        |=> (mem_q[$past(addr_p)][WIDTH/LANES-1:0] == $past(chk_old[WIDTH/LANES-1:0])))
        else $error("lane 0 changed with select high");

    lane_top_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_burst && pos_sel_n[LANES-1] && addr_p != addr_n)
        |=> (mem_q[$past(addr_p)][WIDTH-1 -: WIDTH/LANES]
             == $past(chk_old[WIDTH-1 -: WIDTH/LANES])))
        else $error("top lane changed with select high");

    top_lane_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (in_burst && !neg_sel_n[LANES-1] && addr_p != addr_n)
        |=> (mem_q[$past(addr_n)][WIDTH-1 -: WIDTH/LANES]
             == $past(neg_data[WIDTH-1 -: WIDTH/LANES])))
        else $error("negative beat top lane not stored");

    burst_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        burst_open |=> burst_tail)
        else $error("burst did not span two cycles");

    beat_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (busy && !wr_start) |-> (addr_p == $past(wr_addr) + AW'(2'h2)))
        else $error("second cycle positive beat address wrong");

    beat_addr_n_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (busy && !wr_start) |-> (addr_n == $past(wr_addr) + AW'(2'h3)))
        else $error("second cycle negative beat address wrong");

    // The array has no reset, so only the registered outputs are checked here.
    reset_clear_a: assert property (@(posedge core_clk)
        !rst_n |=> (!busy && rd_data == '0))
        else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// ===== bench/swlm_ctrl_model.sv
// Memory controller model that drives masked write bursts.
`timescale 1ns/1ps
`default_nettype none
module swlm_ctrl_model (
    input wire logic core_clk,
    output logic wr_start,
    output logic [3:0] wr_addr,
    output logic [35:0] pos_data,
    output logic [3:0] pos_sel_n,
    output logic [35:0] neg_data,
    output logic [3:0] neg_sel_n
);
    initial
    begin
        wr_start = 1'b0;
        wr_addr = 4'h0;
        pos_data = 36'h0;
        neg_data = 36'h0;
        pos_sel_n = 4'hf;
        neg_sel_n = 4'hf;
    end
    // Beat b of the burst is d[b*36 +: 36] with selects s[b*4 +: 4].
    task automatic burst(input logic [3:0] a, input logic [143:0] d, input logic [15:0] s);
        for (int c = 0; c < 2; c++)
        begin
            @(posedge core_clk);
            #1;
            wr_start = (c == 0);
            wr_addr = (c == 0) ? a : ~a;
            pos_data = d[c*72 +: 36];
            neg_data = d[c*72+36 +: 36];
            pos_sel_n = s[c*8 +: 4];
            neg_sel_n = s[c*8+4 +: 4];
        end
    endtask
    // Scrambled data and high selects after release, so stale beats cannot pass.
    task automatic idle();
        @(posedge core_clk);
        #1;
        wr_start = 1'b0;
        pos_data = ~pos_data;
        neg_data = ~neg_data;
        pos_sel_n = 4'hf;
        neg_sel_n = 4'hf;
    endtask
endmodule
`default_nettype wire

// ===== bench/test_swlm_write_lane_mask.sv
// Self-checking bench for the write lane mask block in all four widths.
`timescale 1ns/1ps
`default_nettype none
module test_swlm_write_lane_mask;
    logic core_clk;
    logic rst_n;
    logic wr_start;
    logic [3:0] wr_addr;
    logic [35:0] pos_data;
    logic [3:0] pos_sel_n;
    logic [35:0] neg_data;
    logic [3:0] neg_sel_n;
    logic [3:0] rd_addr;
    logic [35:0] rd_data;
    logic busy;
    logic [35:0] exp_mem [16];
    // The narrow variants share the controller's low lanes and selects.
    logic [7:0] rd_data_x8;
    logic [8:0] rd_data_x9;
    logic [17:0] rd_data_x18;
    logic [7:0] exp_x8 [16];
    logic [8:0] exp_x9 [16];
    logic [17:0] exp_x18 [16];
    int fails;
    int total_checks;
    swlm_write_lane_mask u_swlm_write_lane_mask (.core_clk(core_clk), .rst_n(rst_n),
        .wr_start(wr_start), .wr_addr(wr_addr), .pos_data(pos_data), .pos_sel_n(pos_sel_n),
        .neg_data(neg_data), .neg_sel_n(neg_sel_n), .rd_addr(rd_addr), .rd_data(rd_data),
        .busy(busy));
    swlm_ctrl_model u_swlm_ctrl_model (.core_clk(core_clk), .wr_start(wr_start),
        .wr_addr(wr_addr), .pos_data(pos_data), .pos_sel_n(pos_sel_n), .neg_data(neg_data),
        .neg_sel_n(neg_sel_n));
    swlm_write_lane_mask #(.WIDTH(swlm_pkg::W_X8), .LANES(swlm_pkg::W_X8 / swlm_pkg::NIB_W))
        u_swlm_write_lane_mask_x8 (.core_clk(core_clk), .rst_n(rst_n), .wr_start(wr_start),
        .wr_addr(wr_addr), .pos_data(pos_data[7:0]), .pos_sel_n(pos_sel_n[1:0]),
        .neg_data(neg_data[7:0]), .neg_sel_n(neg_sel_n[1:0]), .rd_addr(rd_addr),
        .rd_data(rd_data_x8), .busy());
    swlm_write_lane_mask #(.WIDTH(swlm_pkg::W_X9), .LANES(1))
        u_swlm_write_lane_mask_x9 (.core_clk(core_clk), .rst_n(rst_n), .wr_start(wr_start),
        .wr_addr(wr_addr), .pos_data(pos_data[8:0]), .pos_sel_n(pos_sel_n[0]),
        .neg_data(neg_data[8:0]), .neg_sel_n(neg_sel_n[0]), .rd_addr(rd_addr),
        .rd_data(rd_data_x9), .busy());
    swlm_write_lane_mask #(.WIDTH(swlm_pkg::W_X18), .LANES(swlm_pkg::W_X18 / swlm_pkg::LANE_W))
        u_swlm_write_lane_mask_x18 (.core_clk(core_clk), .rst_n(rst_n), .wr_start(wr_start),
        .wr_addr(wr_addr), .pos_data(pos_data[17:0]), .pos_sel_n(pos_sel_n[1:0]),
        .neg_data(neg_data[17:0]), .neg_sel_n(neg_sel_n[1:0]), .rd_addr(rd_addr),
        .rd_data(rd_data_x18), .busy());
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every lane of every beat carries a distinct value, so a misplaced lane shows.
    task automatic write(input logic [3:0] a, input logic [4:0] seed, input logic [15:0] s);
        logic [143:0] d;
        for (int b = 0; b < 4; b++)
            for (int l = 0; l < 4; l++)
            begin
                d[b*36+l*9 +: 9] = {seed, 2'(b), 2'(l)};
                if (!s[b*4+l])
                begin
                    exp_mem[4'(a+b)][l*9 +: 9] = d[b*36+l*9 +: 9];
                    // Nibble, half-width and single-lane parts obey the same low selects.
                    if (l < 2)
                    begin
                        exp_x8[4'(a+b)][l*4 +: 4] = d[b*36+l*4 +: 4];
                        exp_x18[4'(a+b)][l*9 +: 9] = d[b*36+l*9 +: 9];
                    end
                    if (l == 0)
                        exp_x9[4'(a+b)] = d[b*36 +: 9];
                end
            end
        u_swlm_ctrl_model.burst(a, d, s);
        check(36'(busy), 36'h1);
    endtask
    task automatic check_all();
        for (int i = 0; i < 16; i++)
        begin
            @(posedge core_clk);
            #1;
            rd_addr = 4'(i);
            @(posedge core_clk);
            #1;
            check(rd_data, exp_mem[i]);
            check(36'(rd_data_x8), 36'(exp_x8[i]));
            check(36'(rd_data_x18), 36'(exp_x18[i]));
            check(36'(rd_data_x9), 36'(exp_x9[i]));
        end
    endtask
    task automatic fill_all();
        for (int k = 0; k < 4; k++)
            write(4'(k*4), 5'(k + 8), 16'h0000);
        u_swlm_ctrl_model.idle();
        check(36'(busy), 36'h0);
        check_all();
    endtask
    task automatic lane_mix();
        write(4'h2, 5'h11, 16'h7bde);
        write(4'he, 5'h12, 16'hf0f3);
        write(4'h8, 5'h13, 16'hffff);
        u_swlm_ctrl_model.idle();
        check(36'(busy), 36'h0);
        check_all();
    endtask
    // A reset in mid-run clears the outputs but leaves the array as it was.
    task automatic mid_reset();
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check(rd_data, 36'h0);
        check(36'(busy), 36'h0);
        rst_n = 1'b1;
        write(4'h6, 5'h14, 16'h5a0f);
        u_swlm_ctrl_model.idle();
        check(36'(busy), 36'h0);
        check_all();
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial
    begin
        rst_n = 1'b0;
        rd_addr = 4'h0;
        fails = 0;
        total_checks = 0;
        repeat (10) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        fill_all();
        lane_mix();
        mid_reset();
        close_out();
    end
endmodule
`default_nettype wire
